// ---- shared/dpcs_pkg.sv ----
package dpcs_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CORE_CTRL = 8'h00;
  localparam logic [7:0] OFF_CORE_STAT = 8'h04;
  localparam logic [7:0] OFF_PORT_MAP  = 8'h08;
  localparam logic [7:0] OFF_CTRL_ESC  = 8'h0c;
  localparam logic [7:0] OFF_PHY_ESC   = 8'h10;
  localparam logic [7:0] OFF_PLL_BASE  = 8'h20;
  localparam logic [7:0] PLL_STRIDE    = 8'h10;
  // Offsets inside one PLL group
  localparam logic [3:0] SUB_PWR_LOCK  = 4'h0;
  localparam logic [3:0] SUB_SPREAD    = 4'h4;
  localparam logic [3:0] SUB_DCO       = 4'h8;
  localparam logic [3:0] SUB_DIVIDER   = 4'hc;
  // pll_power_lock_control fields
  localparam int BIT_PLL_EN    = 31;
  localparam int BIT_PLL_LOCK  = 30;
  localparam int BIT_PWR_REQ   = 27;
  localparam int BIT_PWR_STATE = 26;
  // Reference frequency codes in core_clk_ctrl[10:9]
  localparam logic [1:0] REF_19P2 = 2'h0;
  localparam logic [1:0] REF_24   = 2'h1;
  localparam logic [1:0] REF_38P4 = 2'h2;
  // Port select codes and reset values
  localparam logic [1:0] SEL_PLL_ZERO = 2'h0;
  localparam logic [1:0] SEL_PLL_ONE  = 2'h1;
  localparam logic [1:0] SEL_PLL_FOUR = 2'h2;
  localparam logic [2:0] PORT_OFF_RST = 3'h7;
  localparam logic [8:0] ESC_DIV_RST  = 9'h000;
  // Fixed divisions of the 8X clock
  localparam logic [2:0] BYTE_DIV_LAST = 3'h7;
  // Timing
  localparam int CLK_MHZ      = 200;
  localparam int LOCK_TIME_NS = 50000;
  localparam int LOCK_MAX_CYC = LOCK_TIME_NS * CLK_MHZ / 1000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PS_OFF     = 4'h1,
    PS_POWERED = 4'h2,
    PS_LOCKING = 4'h4,
    PS_LOCKED  = 4'h8
  } dpcs_pll_state_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } dpcs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dpcs_axi_rsp_t;
endpackage

// ---- core/dpcs_top.sv ----
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Contract
// - Core display domain runs at half reference while its PLL is off.
// - Core PLL resets disabled; power transitions may force it off.
// - 19.2/38.4 MHz ratio and divider pairs map to listed core clocks.
// - 24 MHz ratio and divider pairs map to listed core clocks.
// - Escape timing divides byte clock by N equal to ceiling of M/8.
// - Low-power transmit signals registered on byte clock, change at escape rate.
// - Receive escape clock is XOR of received low-power lines, forwarded.
// - A FIFO absorbs phase between forwarded and direct byte clocks.
// - 4X and 1X clocks fixed divisions of 8X; escape variable division.
// - Power request first; power status reported at once; read flushes writes.
// - Lock reported within 50 us of enable; map ports only after lock.
// - Gate ports, clear enable; lock drops within 1 us.
// - After unlock remove power; power-off status reported at once.
// - 19.2/38.4 MHz link rates use the listed DCO integer/fraction pairs.
// - 24 MHz link rates use the listed DCO integer/fraction pairs.
// - P, K and Q fields decode to listed ratios; Q is 1 unless Q mode set.
// - Tunnel PLL and unavailable PLL are not used; two-port parts use two.
// - Select code 00 routes PLL zero to port A; off bit 0 ungates it.
module dpcs_top #(
  parameter int LOCK_CYCLES   = dpcs_pkg::LOCK_MAX_CYC, // Lock wait
  parameter bit TWO_PORT_PART = 1'b0,                   // Two combo ports
  parameter int FIFO_DEPTH    = 4                       // Phase FIFO depth
) (
  input  wire logic                    clk_in,            // 200 MHz clock
  input  wire logic                    rst_n_in,          // Sync reset
  input  wire dpcs_pkg::dpcs_axi_req_t axi_req_in,        // AXI4-Lite in
  output dpcs_pkg::dpcs_axi_rsp_t      axi_rsp_out,       // AXI4-Lite out
  input  wire logic                    pwr_transition_in, // Power state pin
  input  wire logic                    core_lock_in,      // Core PLL lock pin
  input  wire logic [1:0]              lp_tx_in,          // LP tx from ctrl
  input  wire logic [1:0]              lp_rx_in,          // LP rx line pins
  input  wire logic [7:0]              hs_byte_in,        // Forwarded byte
  input  wire logic                    hs_valid_in,       // Byte valid
  output logic                         core_pll_en_out,   // Core PLL enable
  output logic [6:0]                   core_ratio_out,    // Core PLL ratio
  output logic                         core_div2_out,     // Doubled clk /2
  output logic                         core_sel_pll_out,  // 1 PLL, 0 ref/2
  output logic [2:0]                   pll_pwr_out,       // Combo PLL power
  output logic [2:0]                   pll_en_out,        // Combo PLL enable
  output logic [2:0]                   pll_ssc_out,       // Spread enable
  output logic [5:0]                   port_sel_out,      // Port clock select
  output logic [2:0]                   port_clk_on_out,   // Port clock ungate
  output logic                         quad_tick_out,     // 4X strobe
  output logic                         byte_tick_out,     // 1X strobe
  output logic                         esc_tick_out,      // Escape strobe
  output logic [1:0]                   lp_tx_out,         // LP tx to phy
  output logic                         esc_rx_clk_out,    // Rx escape clock
  output logic [7:0]                   hs_byte_out,       // Byte to AFE
  output logic                         hs_valid_out       // Byte valid
);
  import dpcs_pkg::*;

  localparam int NP = 3;

  // Refuse settings the counters and FIFO pointers cannot hold
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535 || FIFO_DEPTH != 4) begin : g_chk
    $error("dpcs_top: unsupported parameter value");
  end

  // Core clock in 100 kHz units, zero when the pair is unsupported
  function automatic logic [15:0] core_freq(input logic [1:0] rf,
                                            input logic [6:0] ratio,
                                            input logic       div2);
    logic [7:0] r;
    r = (rf == REF_38P4) ? {ratio, 1'b0} : {1'b0, ratio};
    core_freq = 16'h0000;
    if (rf == REF_24) begin
      unique case ({r, div2})
        {8'd15, 1'b0}: core_freq = 16'd1800;
        {8'd16, 1'b0}: core_freq = 16'd1920;
        {8'd26, 1'b0}: core_freq = 16'd3120;
        {8'd54, 1'b1}: core_freq = 16'd3240;
        {8'd46, 1'b0}: core_freq = 16'd5520;
        {8'd54, 1'b0}: core_freq = 16'd6480;
        default:       core_freq = 16'h0000;
      endcase
    end else if (rf == REF_19P2 || rf == REF_38P4) begin
      // 38.4 ratios are half the 19.2 ones
      unique case ({r, div2})
        {8'd18, 1'b0}: core_freq = 16'd1728;
        {8'd20, 1'b0}: core_freq = 16'd1920;
        {8'd32, 1'b0}: core_freq = 16'd3072;
        {8'd68, 1'b1}: core_freq = 16'd3264;
        {8'd58, 1'b0}: core_freq = 16'd5568;
        {8'd68, 1'b0}: core_freq = 16'd6528;
        default:       core_freq = 16'h0000;
      endcase
    end
  endfunction

  // Known link-rate DCO settings for the reference in use
  function automatic logic dco_known(input logic [1:0]  rf,
                                     input logic [9:0]  dint,
                                     input logic [14:0] frac);
    if (rf == REF_24) begin
      dco_known = (dint == 10'h151 && frac == 15'h4000) ||
                  (dint == 10'h168 && frac == 15'h0000) ||
                  (dint == 10'h195 && frac == 15'h0000);
    end else begin
      // 19.2 and 38.4 MHz DCO pairs
      dco_known = (dint == 10'h1a5 && frac == 15'h7000) ||
                  (dint == 10'h1c2 && frac == 15'h0000) ||
                  (dint == 10'h1fa && frac == 15'h2000);
    end
  endfunction

  // Decoded P, K, Q and a valid flag, packed for the divider readback
  function automatic logic [15:0] div_decode(input logic [15:0] raw);
    logic [2:0] p;
    logic [1:0] k;
    logic [7:0] q;
    unique case (raw[3:0])
      4'h1:    p = 3'd2;
      4'h2:    p = 3'd3;
      4'h4:    p = 3'd5;
      default: p = 3'd0;
    endcase
    unique case (raw[6:4])
      3'h1:    k = 2'd1;
      3'h2:    k = 2'd2;
      default: k = 2'd0;
    endcase
    q = raw[7] ? raw[15:8] : 8'h01;
    div_decode = {(p != 3'd0 && k != 2'd0 && q != 8'h00), p, k, 2'b00, q};
  endfunction

  // N = ceiling(M/8) in six bits: one for M of zero, zero for M of 505 and up
  function automatic logic [5:0] esc_n(input logic [8:0] m);
    logic [9:0] s;
    s = {1'b0, m} + 10'd7;
    esc_n = (s[9:3] == 7'd0) ? 6'd1 : s[8:3];
  endfunction

  // Pin synchronisers, first stage read only by the second
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {lp_rx_in, core_lock_in, pwr_transition_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Register state
  logic [31:0]     core_ctrl_ff;
  logic [5:0]      map_sel_ff;
  logic [2:0]      map_off_ff;
  logic [8:0]      ctrl_esc_ff;
  logic [8:0]      phy_esc_ff;
  logic [NP-1:0]   en_ff;
  logic [NP-1:0]   pwr_req_ff;
  logic [NP-1:0]   ssc_ff;
  logic [24:0]     dco_ff [NP];
  logic [15:0]     div_ff [NP];
  dpcs_pll_state_t st_ff [NP];
  dpcs_pll_state_t nxt_st [NP];
  logic [15:0]     cnt_ff [NP];

  // AXI write side: address and data may come in either order
  logic [7:0]  aw_addr_ff;
  logic        aw_have_ff;
  logic [31:0] w_data_ff;
  logic        w_have_ff;
  logic        wr_go;
  dpcs_axi_rsp_t wr_ff;
  dpcs_axi_rsp_t rd_ff;
  // Each half from its own process, so every field has one driver
  assign axi_rsp_out = '{wr_ff.awready, wr_ff.wready, wr_ff.bvalid,
                         wr_ff.bresp, rd_ff.arready, rd_ff.rvalid,
                         rd_ff.rdata, rd_ff.rresp};
  assign wr_go = aw_have_ff && w_have_ff && !wr_ff.bvalid;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      wr_ff      <= '0;
    end else begin
      wr_ff.awready <= 1'b0;
      wr_ff.wready  <= 1'b0;
      if (axi_req_in.awvalid && !aw_have_ff && !wr_ff.awready) begin
        aw_have_ff    <= 1'b1;
        aw_addr_ff    <= axi_req_in.awaddr;
        wr_ff.awready <= 1'b1;
      end
      if (axi_req_in.wvalid && !w_have_ff && !wr_ff.wready) begin
        w_have_ff    <= 1'b1;
        w_data_ff    <= axi_req_in.wdata;
        wr_ff.wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        wr_ff.bvalid <= 1'b1;
        wr_ff.bresp  <= wr_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (wr_ff.bvalid && axi_req_in.bready) begin
        wr_ff.bvalid <= 1'b0;
      end
    end
  end

  // Mapped write addresses
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = (a == OFF_CORE_CTRL) || (a == OFF_PORT_MAP) ||
             (a == OFF_CTRL_ESC) || (a == OFF_PHY_ESC) ||
             (a >= OFF_PLL_BASE && a < OFF_PLL_BASE + 8'h30 &&
              a[1:0] == 2'b00);
  endfunction

  // Register writes; wstrb ignored since every field is one word
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // core PLL disabled out of reset
      core_ctrl_ff <= 32'h0000_0000;
      map_sel_ff   <= 6'h00;
      map_off_ff   <= PORT_OFF_RST;
      ctrl_esc_ff  <= ESC_DIV_RST;
      phy_esc_ff   <= ESC_DIV_RST;
      en_ff        <= '0;
      pwr_req_ff   <= '0;
      ssc_ff       <= '0;
      for (int i = 0; i < NP; i++) begin
        dco_ff[i] <= 25'h0000000;
        div_ff[i] <= 16'h0000;
      end
    end else if (wr_go) begin
      unique case (aw_addr_ff)
        OFF_CORE_CTRL: core_ctrl_ff <= {21'h000000, w_data_ff[10:0]};
        // select codes and active-high off bits
        OFF_PORT_MAP: begin
          map_sel_ff <= w_data_ff[5:0];
          map_off_ff <= w_data_ff[10:8];
        end
        OFF_CTRL_ESC: ctrl_esc_ff <= w_data_ff[8:0];
        OFF_PHY_ESC:  phy_esc_ff  <= w_data_ff[8:0];
        default: begin
          for (int i = 0; i < NP; i++) begin
            if (aw_addr_ff[7:4] == 4'(2 + i)) begin
              unique case (aw_addr_ff[3:0])
                SUB_PWR_LOCK: begin
                  en_ff[i]      <= w_data_ff[BIT_PLL_EN];
                  pwr_req_ff[i] <= w_data_ff[BIT_PWR_REQ];
                end
                SUB_SPREAD:  ssc_ff[i] <= w_data_ff[0];
                SUB_DCO:     dco_ff[i] <= w_data_ff[24:0];
                SUB_DIVIDER: div_ff[i] <= w_data_ff[15:0];
                default: ;
              endcase
            end
          end
        end
      endcase
    end
  end

  // PLL power and lock sequencing
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      nxt_st[i] = st_ff[i];
      // index 2 is combo PLL four, absent on two-port parts
      if (!pwr_req_ff[i] || (TWO_PORT_PART && i == 2)) begin
        // power status follows the request at once
        nxt_st[i] = PS_OFF;
      end else begin
        unique case (st_ff[i])
          // power enabled status reported the next cycle
          PS_OFF:     nxt_st[i] = PS_POWERED;
          PS_POWERED: nxt_st[i] = en_ff[i] ? PS_LOCKING : PS_POWERED;
          // lock after LOCK_CYCLES, within 50 us
          PS_LOCKING: begin
            if (!en_ff[i]) begin
              nxt_st[i] = PS_POWERED;
            end else if (cnt_ff[i] == 16'(LOCK_CYCLES - 1)) begin
              nxt_st[i] = PS_LOCKED;
            end
          end
          // enable clear drops lock next cycle
          PS_LOCKED:  nxt_st[i] = en_ff[i] ? PS_LOCKED : PS_POWERED;
          default:    nxt_st[i] = PS_OFF;
        endcase
      end
    end
  end

  // State, lock counter and PLL control pins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NP; i++) begin
        st_ff[i]  <= PS_OFF;
        cnt_ff[i] <= 16'h0000;
      end
      pll_pwr_out <= 3'h0;
      pll_en_out  <= 3'h0;
      pll_ssc_out <= 3'h0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        st_ff[i]  <= nxt_st[i];
        cnt_ff[i] <= (st_ff[i] == PS_LOCKING) ? cnt_ff[i] + 16'h0001
                                              : 16'h0000;
        pll_pwr_out[i] <= (nxt_st[i] != PS_OFF);
        // no enable to an unpowered PLL
        pll_en_out[i]  <= (nxt_st[i] == PS_LOCKING) ||
                          (nxt_st[i] == PS_LOCKED);
        pll_ssc_out[i] <= ssc_ff[i];
      end
    end
  end

  // Core clock source; hardware may override during power transitions
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      core_pll_en_out  <= 1'b0;
      core_ratio_out   <= 7'h00;
      core_div2_out    <= 1'b0;
      core_sel_pll_out <= 1'b0;
    end else begin
      // power transition forces the core PLL off
      core_pll_en_out  <= core_ctrl_ff[0] && !sync2_ff[0];
      core_ratio_out   <= core_ctrl_ff[7:1];
      core_div2_out    <= core_ctrl_ff[8];
      // half reference unless PLL enabled and locked
      core_sel_pll_out <= core_pll_en_out && sync2_ff[1];
    end
  end

  // Port clock mapping; gate stays shut unless the chosen PLL is locked
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      port_sel_out    <= 6'h00;
      port_clk_on_out <= 3'h0;
    end else begin
      port_sel_out <= map_sel_ff;
      for (int p = 0; p < 3; p++) begin
        // off bit 0 ungates the selected PLL's clock
        port_clk_on_out[p] <= !map_off_ff[p] &&
                              map_sel_ff[2*p +: 2] != 2'h3 &&
                              st_ff[map_sel_ff[2*p +: 2]] == PS_LOCKED;
      end
    end
  end

  // 8X clock divisions and escape emulation
  logic [2:0] div8_ff;
  logic [5:0] esc_cnt_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div8_ff       <= 3'h0;
      esc_cnt_ff    <= 6'h00;
      quad_tick_out <= 1'b0;
      byte_tick_out <= 1'b0;
      esc_tick_out  <= 1'b0;
      lp_tx_out     <= 2'h0;
    end else begin
      // fixed /2 and /8, variable escape division
      div8_ff       <= div8_ff + 3'h1;
      quad_tick_out <= div8_ff[0];
      byte_tick_out <= (div8_ff == BYTE_DIV_LAST);
      esc_tick_out  <= 1'b0;
      if (div8_ff == BYTE_DIV_LAST) begin
        // count N byte periods per escape period
        if (esc_cnt_ff >= esc_n(ctrl_esc_ff) - 6'h01) begin
          esc_cnt_ff   <= 6'h00;
          esc_tick_out <= 1'b1;
          // LP tx moves only on escape boundaries
          lp_tx_out    <= lp_tx_in;
        end else begin
          esc_cnt_ff <= esc_cnt_ff + 6'h01;
        end
      end
    end
  end

  // Receive escape clock from the synchronised line pair
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      esc_rx_clk_out <= 1'b0;
    end else begin
      esc_rx_clk_out <= sync2_ff[3] ^ sync2_ff[2];
    end
  end

  // Phase FIFO: reads start once half full so jitter either way is absorbed
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [2:0] wp_ff;
  logic [2:0] rp_ff;
  logic       primed_ff;
  logic [2:0] fill;
  assign fill = wp_ff - rp_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_ff        <= 3'h0;
      rp_ff        <= 3'h0;
      primed_ff    <= 1'b0;
      hs_byte_out  <= 8'h00;
      hs_valid_out <= 1'b0;
    end else begin
      // elastic store between byte clock phases
      if (hs_valid_in && fill != 3'h4) begin
        fifo_mem[wp_ff[1:0]] <= hs_byte_in;
        wp_ff <= wp_ff + 3'h1;
      end
      if (fill >= 3'h2) begin
        primed_ff <= 1'b1;
      end else if (fill == 3'h0) begin
        primed_ff <= 1'b0;
      end
      hs_valid_out <= 1'b0;
      if (primed_ff && fill != 3'h0) begin
        hs_byte_out  <= fifo_mem[rp_ff[1:0]];
        hs_valid_out <= 1'b1;
        rp_ff        <= rp_ff + 3'h1;
      end
    end
  end

  // AXI read; held off while any write is half or fully taken
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_ff <= '0;
    end else begin
      rd_ff.arready <= 1'b0;
      if (rd_ff.rvalid) begin
        if (axi_req_in.rready) begin
          rd_ff.rvalid <= 1'b0;
        end
      // reads wait until pending writes have landed
      end else if (axi_req_in.arvalid && !rd_ff.arready &&
                   !aw_have_ff && !w_have_ff && !axi_req_in.awvalid &&
                   !axi_req_in.wvalid) begin
        rd_ff.arready <= 1'b1;
        rd_ff.rvalid  <= 1'b1;
        rd_ff.rresp   <= wr_hit(axi_req_in.araddr) ||
                         axi_req_in.araddr == OFF_CORE_STAT ?
                         RESP_OKAY : RESP_SLVERR;
        rd_ff.rdata   <= rd_mux(axi_req_in.araddr);
      end
    end
  end

  // Read data selection
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [15:0] f;
    logic [1:0]  rf;
    logic [1:0]  i;
    f  = core_freq(core_ctrl_ff[10:9], core_ctrl_ff[7:1], core_ctrl_ff[8]);
    rf = core_ctrl_ff[10:9];
    i  = 2'(a[7:4] - 4'h2);
    rd_mux = 32'h0000_0000;
    if (a == OFF_CORE_CTRL) begin
      rd_mux = core_ctrl_ff;
    end else if (a == OFF_CORE_STAT) begin
      rd_mux = {f, 13'h0000, (f != 16'h0000), sync2_ff[0],
                core_sel_pll_out};
    end else if (a == OFF_PORT_MAP) begin
      rd_mux = {21'h000000, map_off_ff, 2'h0, map_sel_ff};
    end else if (a == OFF_CTRL_ESC) begin
      rd_mux = {10'h000, esc_n(ctrl_esc_ff), 7'h00, ctrl_esc_ff};
    end else if (a == OFF_PHY_ESC) begin
      rd_mux = {23'h000000, phy_esc_ff};
    end else if (wr_hit(a) && i < 2'(NP)) begin
      unique case (a[3:0])
        SUB_PWR_LOCK: rd_mux = {en_ff[i], st_ff[i] == PS_LOCKED, 2'h0,
                                pwr_req_ff[i], st_ff[i] != PS_OFF, 26'h0};
        SUB_SPREAD:   rd_mux = {31'h00000000, ssc_ff[i]};
        SUB_DCO:      rd_mux = {dco_known(rf, dco_ff[i][9:0],
                                  dco_ff[i][24:10]), 6'h00, dco_ff[i]};
        SUB_DIVIDER:  rd_mux = {div_decode(div_ff[i]), div_ff[i]};
        default:      rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction
endmodule

// ---- dv/dpcs_chk.sv ----
`timescale 1ns/1ps
module dpcs_chk (
  input wire logic       clk_in,            // Clock
  input wire logic       rst_n_in,          // Reset
  input wire logic       pwr_transition_in, // Forced off
  input wire logic       core_pll_en_out,   // Core PLL on
  input wire logic       core_sel_pll_out,  // Core source
  input wire logic [2:0] pll_pwr_out,       // PLL power
  input wire logic [2:0] pll_en_out,        // PLL enable
  input wire logic [2:0] port_clk_on_out,   // Port ungate
  input wire logic       quad_tick_out,     // 4X strobe
  input wire logic       byte_tick_out,     // 1X strobe
  input wire logic       esc_tick_out,      // Escape strobe
  input wire logic [1:0] lp_tx_out,         // LP tx
  input wire logic [1:0] lp_rx_in,          // LP rx
  input wire logic       esc_rx_clk_out     // Rx escape
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Port behaviour; sync delays allow two flops plus one register
  sel_src_a: assert property (
    core_sel_pll_out |-> $past(core_pll_en_out))
    else $error("core source without enable");
  hw_off_a: assert property (
    pwr_transition_in [*4] |-> !core_pll_en_out)
    else $error("core PLL not forced off");
  esc_on_byte_a: assert property (
    esc_tick_out |-> byte_tick_out)
    else $error("escape strobe off byte boundary");
  quad_rate_a: assert property (
    quad_tick_out |=> !quad_tick_out ##1 quad_tick_out)
    else $error("4X strobe period wrong");
  byte_rate_a: assert property (
    byte_tick_out |=> !byte_tick_out [*7] ##1 byte_tick_out)
    else $error("1X strobe period wrong");
  lp_step_a: assert property (
    $changed(lp_tx_out) |-> esc_tick_out)
    else $error("LP tx moved off escape tick");
  rx_xor_a: assert property (
    $stable(lp_rx_in) [*4] |-> esc_rx_clk_out == ^lp_rx_in)
    else $error("rx escape clock not XOR");
  gate_lock_a: assert property (
    port_clk_on_out != 3'h0 |-> $past(pll_en_out, 3) != 3'h0)
    else $error("port ungated without PLL");
  pwr_drop_a: assert property (
    !pll_pwr_out[0] [*3] |-> !pll_en_out[0])
    else $error("PLL enabled while unpowered");
endmodule
bind dpcs_top dpcs_chk u_chk (.clk_in, .rst_n_in, .pwr_transition_in,
  .core_pll_en_out, .core_sel_pll_out, .pll_pwr_out, .pll_en_out,
  .port_clk_on_out, .quad_tick_out, .byte_tick_out, .esc_tick_out,
  .lp_tx_out, .lp_rx_in, .esc_rx_clk_out);

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  import dpcs_pkg::*;
  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  logic          pwr_tr = 1'b0;
  logic          lock = 1'b0;
  logic [7:0]    cnt = 8'h00;
  dpcs_axi_req_t q = '0;
  dpcs_axi_rsp_t p;
  logic          en;
  logic          sel;
  logic [2:0]    on;
  logic [31:0]   d;
  logic [1:0]    r;
  int            n_errors = 0;
  int            n_tests = 0;
  // Write addr, read addr, data, mask, expected
  logic [111:0]  rows [19] = '{
    112'h00_04_00000222_ffff0000_00000000,
    112'h00_04_0000036c_ffff0000_0ca80000,
    112'h00_04_00000088_ffff0000_19800000,
    112'h00_04_00000544_ffff0000_0cc00000,
    112'h00_04_0000021e_ffff0000_07080000,
    112'h20_20_08000000_04000000_04000000,
    112'h28_28_01c001a5_80000000_00000000,
    112'h28_28_01000151_80000000_80000000,
    112'h2c_2c_000002a1_fcff0000_a8020000,
    112'h2c_2c_00000022_fcff0000_b8010000,
    112'h0c_0c_00000009_003f0000_00020000,
    112'h0c_0c_00000008_003f0000_00010000,
    112'h0c_0c_000001f8_003f0000_003f0000,
    112'h0c_0c_00000011_003f0000_00030000,
    112'h08_08_00000700_0000073f_00000700,
    112'h08_08_00000600_0000073f_00000600,
    112'h08_08_00000700_0000073f_00000700,
    112'h20_20_08000000_40000000_00000000,
    112'h20_20_00000000_04000000_00000000};
  always #2.5 clk_in = ~clk_in;
  // Slow counter keeps LP lines steady long enough to sync
  always @(posedge clk_in) cnt <= cnt + 8'h01;
  dpcs_top #(.LOCK_CYCLES(16)) uut (.clk_in, .rst_n_in,
    .axi_req_in(q), .axi_rsp_out(p), .pwr_transition_in(pwr_tr),
    .core_lock_in(lock), .lp_tx_in(cnt[4:3]), .lp_rx_in(cnt[6:5]),
    .hs_byte_in(cnt), .hs_valid_in(cnt[2]), .core_pll_en_out(en),
    .core_ratio_out(), .core_div2_out(), .core_sel_pll_out(sel),
    .pll_pwr_out(), .pll_en_out(), .pll_ssc_out(), .port_sel_out(),
    .port_clk_on_out(on), .quad_tick_out(), .byte_tick_out(),
    .esc_tick_out(), .lp_tx_out(), .esc_rx_clk_out(), .hs_byte_out(),
    .hs_valid_out());
  task automatic chk(input string s, input logic [31:0] v, e);
    n_tests++;
    if (v !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", s, e, v);
    end
  endtask
  // One AXI4-Lite access; ready lines held until the answer
  task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] v);
    // Idle edge so a release and the next raise never share a step
    @(posedge clk_in);
    q.awaddr <= a;
    q.araddr <= a;
    q.wdata <= v;
    q.wstrb <= 4'hf;
    q.awvalid <= w;
    q.wvalid <= w;
    q.arvalid <= !w;
    q.bready <= 1'b1;
    q.rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (p.awready) q.awvalid <= 1'b0;
      if (p.wready) q.wvalid <= 1'b0;
      if (p.arready) q.arvalid <= 1'b0;
    end while (!(p.bvalid || p.rvalid));
    d = p.rdata;
    r = w ? p.bresp : p.rresp;
    q.bready <= 1'b0;
    q.rready <= 1'b0;
  endtask
  task automatic run(input int lo, hi);
    for (int i = lo; i <= hi; i++) begin
      acc(1'b1, rows[i][111:104], rows[i][95:64]);
      acc(1'b0, rows[i][103:96], 32'h0);
      chk($sformatf("row %0d", i), d & rows[i][63:32], rows[i][31:0]);
    end
  endtask
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("core_en", {31'h0, en}, 32'h0);
    run(0, 13);
    $display("register test done");
    lock <= 1'b1;
    acc(1'b1, OFF_CORE_CTRL, 32'h21f);
    repeat (6) @(posedge clk_in);
    chk("core_sel", {31'h0, sel}, 32'h1);
    pwr_tr <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk("core_en", {31'h0, en}, 32'h0);
    chk("core_sel", {31'h0, sel}, 32'h0);
    pwr_tr <= 1'b0;
    $display("core clock test done");
    acc(1'b1, OFF_PLL_BASE, 32'h88000000);
    d = 32'h0;
    for (int i = 0; i < 40 && !d[30]; i++) acc(1'b0, OFF_PLL_BASE, 32'h0);
    chk("lock", d & 32'h40000000, 32'h40000000);
    run(14, 15);
    repeat (2) @(posedge clk_in);
    chk("port_on", {29'h0, on}, 32'h1);
    run(16, 18);
    acc(1'b0, 8'hf0, 32'h0);
    chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("pll sequence test done");
    tally_and_finish();
  end
  // Watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    tally_and_finish();
  end
endmodule
